// File: logic/speed_aux_pkg.sv
// constants, register map and carrier types for the speed-mode helper
// Behaviour
// - zero-lock enable active and |command| <= threshold enters the locked state
// - locked: position loop holds within one pulse of captured position
// - external displacement while locked is driven back to the lock position
// - |command| above threshold leaves lock and follows the command again
// - zero-lock enable inactive never allows the locked state
// - zero-lock threshold register, 0 to 32767 rpm, default 5, immediate
// - forward jog adds jog speed, reverse jog subtracts it
// - command-reverse input negates the speed command
// - speed-pause input forces the effective command to zero
// - consistency output when |filtered speed - command| below threshold
// - speed-reached output when |filtered speed| above threshold
// - zero-speed output when |filtered speed| below zero-speed threshold
// - accelerating output when acceleration exceeds shared threshold
// - decelerating output when deceleration exceeds shared threshold
// - forward output when filtered speed above zero-speed threshold
// - reverse output when filtered speed below negated zero-speed threshold
// - speed feedback low-pass filtered with feedback time constant
// - display speed filtered separately with its own time constant
// - reverse torque limit B value 0 to 3000 tenths, default 1500
package speed_aux_pkg;
	localparam logic [7:0] ZL_THR_ADDR   = 8'h00;
	localparam logic [7:0] JOG_ADDR      = 8'h04;
	localparam logic [7:0] CONS_ADDR     = 8'h08;
	localparam logic [7:0] REACH_ADDR    = 8'h0c;
	localparam logic [7:0] ZSPD_ADDR     = 8'h10;
	localparam logic [7:0] ACC_ADDR      = 8'h14;
	localparam logic [7:0] FBK_TC_ADDR   = 8'h18;
	localparam logic [7:0] DSP_TC_ADDR   = 8'h1c;
	localparam logic [7:0] TLB_SRC_ADDR  = 8'h20;
	localparam logic [7:0] TLB_VAL_ADDR  = 8'h24;
	localparam logic [7:0] STATUS_ADDR   = 8'h28;
	localparam logic [7:0] FSPD_ADDR     = 8'h2c;
	localparam logic [7:0] DSPD_ADDR     = 8'h30;
	localparam logic [7:0] ECMD_ADDR     = 8'h34;
	localparam logic [15:0] ZL_THR_RST   = 16'h0005;
	localparam logic [15:0] ZL_THR_MAX   = 16'h7fff;
	localparam logic [15:0] JOG_RST      = 16'h0014;
	localparam logic [15:0] CONS_RST     = 16'h000a;
	localparam logic [15:0] REACH_RST    = 16'h03e8;
	localparam logic [15:0] ZSPD_RST     = 16'h000a;
	localparam logic [15:0] ACC_RST      = 16'h0064;
	localparam logic [3:0]  FBK_TC_RST   = 4'h2;
	localparam logic [3:0]  DSP_TC_RST   = 4'h4;
	localparam logic [1:0]  TLB_SRC_RST  = 2'h0;
	localparam logic [15:0] TLB_VAL_RST  = 16'h05dc;
	localparam logic [15:0] TLB_VAL_MAX  = 16'h0bb8;
	localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;
	typedef struct packed {
		logic zero_lock_enable_input;
		logic forward_jog_input;
		logic reverse_jog_input;
		logic command_reverse_input;
		logic speed_pause_input;
	} din_s;
	typedef struct packed {
		logic speed_consistency_output;
		logic speed_reached_output;
		logic zero_speed_output;
		logic accelerating_output;
		logic decelerating_output;
		logic forward_rotation_output;
		logic reverse_rotation_output;
		logic locked;
	} dout_s;
	typedef enum logic [1:0] {
		ST_FOLLOW = 2'b01,
		ST_LOCKED = 2'b10
	} lock_state_e;
endpackage

// File: logic/speed_aux.sv
// speed-mode zero lock, command shaping, filters and status outputs
module speed_aux
(
	input  wire logic                 pclk,         // 50 mhz clock
	input  wire logic                 presetn,      // async reset, low
	input  wire logic                 psel,         // apb select
	input  wire logic                 penable,      // apb access phase
	input  wire logic                 pwrite,       // apb direction
	input  wire logic [7:0]           paddr,        // apb byte address
	input  wire logic [31:0]          pwdata,       // apb write data
	output logic      [31:0]          prdata,       // apb read data
	output logic                      pready,       // apb ready
	output logic                      pslverr,      // apb error
	input  wire logic                 loop_tick,    // control update strobe
	input  wire logic signed [15:0]   speed_cmd,    // raw command, rpm
	input  wire logic signed [15:0]   speed_fb,     // raw feedback, rpm
	input  wire logic signed [31:0]   enc_pos,      // encoder count
	input  wire speed_aux_pkg::din_s  din_pins,     // asynchronous inputs
	output logic signed [15:0]        eff_cmd,      // speed loop command
	output logic signed [15:0]        pos_corr,     // lock position command
	output logic [15:0]               tlb_limit,    // reverse limit b, 0.1%
	output speed_aux_pkg::dout_s      dout          // status outputs
);
	speed_aux_pkg::din_s        din_s1;
	speed_aux_pkg::din_s        din_s2;
	speed_aux_pkg::lock_state_e state_reg;
	logic [15:0]        zl_thr_reg;
	logic [15:0]        jog_reg;
	logic [15:0]        cons_reg;
	logic [15:0]        reach_reg;
	logic [15:0]        zspd_reg;
	logic [15:0]        acc_reg;
	logic [3:0]         fbk_tc_reg;
	logic [3:0]         dsp_tc_reg;
	logic [1:0]         tlb_src_reg;
	logic [15:0]        tlb_val_reg;
	logic signed [31:0] fb_acc_reg;
	logic signed [31:0] dsp_acc_reg;
	logic signed [15:0] fspd;
	logic signed [15:0] dspd;
	logic signed [15:0] prev_fspd_reg;
	logic signed [31:0] lock_pos_reg;
	logic signed [17:0] shaped;
	logic signed [17:0] cmd_abs;
	logic signed [17:0] sp_abs;
	logic signed [17:0] diff_abs;
	logic signed [17:0] dv;
	logic signed [17:0] dv_abs;
	logic signed [17:0] prev_abs;
	logic signed [31:0] pos_err;
	logic               wr_en;
	logic               rd_en;
	logic               lock_ok;

	// two-stage synchroniser on the digital inputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			din_s1 <= '0;
			din_s2 <= '0;
		end
		else
		begin
			din_s1 <= din_pins;
			din_s2 <= din_s1;
		end
	end

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;

	// settings registers; zero-lock threshold and limit b clamped, the 16-bit speed settings masked to 15 bits, the rest to their width
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			zl_thr_reg  <= speed_aux_pkg::ZL_THR_RST;
			jog_reg     <= speed_aux_pkg::JOG_RST;
			cons_reg    <= speed_aux_pkg::CONS_RST;
			reach_reg   <= speed_aux_pkg::REACH_RST;
			zspd_reg    <= speed_aux_pkg::ZSPD_RST;
			acc_reg     <= speed_aux_pkg::ACC_RST;
			fbk_tc_reg  <= speed_aux_pkg::FBK_TC_RST;
			dsp_tc_reg  <= speed_aux_pkg::DSP_TC_RST;
			tlb_src_reg <= speed_aux_pkg::TLB_SRC_RST;
			tlb_val_reg <= speed_aux_pkg::TLB_VAL_RST;
		end
		else if (wr_en)
		begin
			case (paddr)
				speed_aux_pkg::ZL_THR_ADDR:
					zl_thr_reg <= (pwdata[15:0] > speed_aux_pkg::ZL_THR_MAX)
						? speed_aux_pkg::ZL_THR_MAX : pwdata[15:0];
				speed_aux_pkg::JOG_ADDR:    jog_reg    <= {1'b0, pwdata[14:0]};
				speed_aux_pkg::CONS_ADDR:   cons_reg   <= {1'b0, pwdata[14:0]};
				speed_aux_pkg::REACH_ADDR:  reach_reg  <= {1'b0, pwdata[14:0]};
				speed_aux_pkg::ZSPD_ADDR:   zspd_reg   <= {1'b0, pwdata[14:0]};
				speed_aux_pkg::ACC_ADDR:    acc_reg    <= {1'b0, pwdata[14:0]};
				speed_aux_pkg::FBK_TC_ADDR: fbk_tc_reg <= pwdata[3:0];
				speed_aux_pkg::DSP_TC_ADDR: dsp_tc_reg <= pwdata[3:0];
				speed_aux_pkg::TLB_SRC_ADDR: tlb_src_reg <= pwdata[1:0];
				speed_aux_pkg::TLB_VAL_ADDR:
					tlb_val_reg <= (pwdata[15:0] > speed_aux_pkg::TLB_VAL_MAX)
						? speed_aux_pkg::TLB_VAL_MAX : pwdata[15:0];
				default: ;
			endcase
		end
	end

	// apb answer: zero wait, error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				prdata <= speed_aux_pkg::UNMAPPED_RD;
				case (paddr)
					speed_aux_pkg::ZL_THR_ADDR:  prdata <= {16'h0, zl_thr_reg};
					speed_aux_pkg::JOG_ADDR:     prdata <= {16'h0, jog_reg};
					speed_aux_pkg::CONS_ADDR:    prdata <= {16'h0, cons_reg};
					speed_aux_pkg::REACH_ADDR:   prdata <= {16'h0, reach_reg};
					speed_aux_pkg::ZSPD_ADDR:    prdata <= {16'h0, zspd_reg};
					speed_aux_pkg::ACC_ADDR:     prdata <= {16'h0, acc_reg};
					speed_aux_pkg::FBK_TC_ADDR:  prdata <= {28'h0, fbk_tc_reg};
					speed_aux_pkg::DSP_TC_ADDR:  prdata <= {28'h0, dsp_tc_reg};
					speed_aux_pkg::TLB_SRC_ADDR: prdata <= {30'h0, tlb_src_reg};
					speed_aux_pkg::TLB_VAL_ADDR: prdata <= {16'h0, tlb_val_reg};
					speed_aux_pkg::STATUS_ADDR:  prdata <= {24'h0, dout};
					speed_aux_pkg::FSPD_ADDR:
						prdata <= {{16{fspd[15]}}, fspd};
					speed_aux_pkg::DSPD_ADDR:
						prdata <= {{16{dspd[15]}}, dspd};
					speed_aux_pkg::ECMD_ADDR:
						prdata <= {{16{eff_cmd[15]}}, eff_cmd};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// command shaping: reverse, jog offset, pause
	always_comb
	begin
		shaped = 18'(speed_cmd);
		if (din_s2.command_reverse_input)
			shaped = -shaped;
		if (din_s2.forward_jog_input)
			shaped = shaped + 18'(jog_reg);
		if (din_s2.reverse_jog_input)
			shaped = shaped - 18'(jog_reg);
		if (din_s2.speed_pause_input)
			shaped = '0;
		cmd_abs = shaped[17] ? -shaped : shaped;
	end

	assign lock_ok = din_s2.zero_lock_enable_input
		&& (cmd_abs <= 18'(zl_thr_reg));

	// zero lock state and captured position
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg    <= speed_aux_pkg::ST_FOLLOW;
			lock_pos_reg <= '0;
		end
		else if (loop_tick)
		begin
			case (state_reg)
				speed_aux_pkg::ST_FOLLOW:
					if (lock_ok)
					begin
						state_reg    <= speed_aux_pkg::ST_LOCKED;
						lock_pos_reg <= enc_pos;
					end
				speed_aux_pkg::ST_LOCKED:
					if (!lock_ok)
						state_reg <= speed_aux_pkg::ST_FOLLOW;
				default: state_reg <= speed_aux_pkg::ST_FOLLOW;
			endcase
		end
	end

	assign pos_err = lock_pos_reg - enc_pos;

	// speed outputs; locked loop drives back to the lock point
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			eff_cmd  <= '0;
			pos_corr <= '0;
		end
		else if (loop_tick)
		begin
			// lock_ok is the state after this tick, so the command
			// is zeroed on the entry tick and restored on the exit tick
			if (lock_ok)
			begin
				eff_cmd <= '0;
				// dead band of one pulse either side
				if (state_reg == speed_aux_pkg::ST_LOCKED
					&& (pos_err > 32'sd1 || pos_err < -32'sd1))
					pos_corr <= (pos_err > 32'sd32767) ? 16'sh7fff :
						(pos_err < -32'sd32767) ? -16'sh7fff :
						16'(pos_err);
				else
					pos_corr <= '0;
			end
			else
			begin
				eff_cmd  <= (shaped > 18'sd32767) ? 16'sh7fff :
					(shaped < -18'sd32767) ? -16'sh7fff : 16'(shaped);
				pos_corr <= '0;
			end
		end
	end

	// first-order filters, shift gives the time constant
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fb_acc_reg  <= '0;
			dsp_acc_reg <= '0;
		end
		else if (loop_tick)
		begin
			fb_acc_reg  <= fb_acc_reg + ((32'(speed_fb) <<< 16)
				- fb_acc_reg >>> fbk_tc_reg);
			dsp_acc_reg <= dsp_acc_reg + ((32'(fspd) <<< 16)
				- dsp_acc_reg >>> dsp_tc_reg);
		end
	end

	assign fspd = fb_acc_reg[31:16];
	assign dspd = dsp_acc_reg[31:16];

	// comparison terms
	always_comb
	begin
		sp_abs   = fspd[15] ? -18'(fspd) : 18'(fspd);
		diff_abs = 18'(fspd) - 18'(eff_cmd);
		diff_abs = diff_abs[17] ? -diff_abs : diff_abs;
		dv       = 18'(fspd) - 18'(prev_fspd_reg);
		dv_abs   = dv[17] ? -dv : dv;
		prev_abs = prev_fspd_reg[15] ? -18'(prev_fspd_reg)
			: 18'(prev_fspd_reg);
	end

	// status outputs and torque limit b output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dout          <= '0;
			prev_fspd_reg <= '0;
			tlb_limit     <= speed_aux_pkg::TLB_VAL_RST;
		end
		else
		begin
			dout.locked <= (state_reg == speed_aux_pkg::ST_LOCKED);
			tlb_limit   <= (tlb_src_reg == speed_aux_pkg::TLB_SRC_RST)
				? tlb_val_reg : '0;
			if (loop_tick)
			begin
				prev_fspd_reg <= fspd;
				dout.speed_consistency_output <=
					diff_abs < 18'(cons_reg);
				dout.speed_reached_output <=
					sp_abs > 18'(reach_reg);
				dout.zero_speed_output <=
					sp_abs < 18'(zspd_reg);
				// speeding up in magnitude versus slowing down
				dout.accelerating_output <= (dv_abs > 18'(acc_reg))
					&& (sp_abs > prev_abs);
				dout.decelerating_output <= (dv_abs > 18'(acc_reg))
					&& (sp_abs < prev_abs);
				// signed compare, the threshold register is unsigned
				dout.forward_rotation_output <=
					18'(fspd) > signed'(18'(zspd_reg));
				dout.reverse_rotation_output <=
					18'(fspd) < -signed'(18'(zspd_reg));
			end
		end
	end

	chk_lock_needs_enable: assert property (@(posedge pclk)
		disable iff (!presetn)
		(state_reg == speed_aux_pkg::ST_FOLLOW) && loop_tick
		&& !din_s2.zero_lock_enable_input
		|=> state_reg == speed_aux_pkg::ST_FOLLOW)
		else $error("lock entered without enable");
	chk_lock_entry: assert property (@(posedge pclk)
		disable iff (!presetn)
		loop_tick && lock_ok |=> state_reg == speed_aux_pkg::ST_LOCKED)
		else $error("lock not entered");
	chk_lock_exit: assert property (@(posedge pclk)
		disable iff (!presetn)
		loop_tick && !lock_ok |=> state_reg == speed_aux_pkg::ST_FOLLOW)
		else $error("lock not left");
	chk_locked_cmd_zero: assert property (@(posedge pclk)
		disable iff (!presetn)
		loop_tick && lock_ok |=> eff_cmd == 0)
		else $error("command passed while locked");
	chk_pause_zero: assert property (@(posedge pclk)
		disable iff (!presetn)
		loop_tick && din_s2.speed_pause_input
		&& state_reg == speed_aux_pkg::ST_FOLLOW |=> eff_cmd == 0)
		else $error("pause did not zero command");
	chk_zero_vs_rot: assert property (@(posedge pclk)
		disable iff (!presetn)
		dout.zero_speed_output |-> !dout.forward_rotation_output
		&& !dout.reverse_rotation_output)
		else $error("zero speed with rotation");
	chk_fwd_rev_excl: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(dout.forward_rotation_output && dout.reverse_rotation_output))
		else $error("both directions at once");
	chk_reach_update: assert property (@(posedge pclk)
		disable iff (!presetn)
		loop_tick |=> dout.speed_reached_output
		== ($past(sp_abs) > 18'($past(reach_reg))))
		else $error("speed reached wrong");
	chk_acc_dec_excl: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(dout.accelerating_output && dout.decelerating_output))
		else $error("accelerating and decelerating");
	cov_lock: cover property (@(posedge pclk)
		state_reg == speed_aux_pkg::ST_LOCKED);
	cov_jog: cover property (@(posedge pclk)
		loop_tick && din_s2.forward_jog_input);
	cov_reach: cover property (@(posedge pclk) dout.speed_reached_output);
endmodule

// File: dv/motor_model.sv
// motor encoder model, moved by bench pushes and the lock loop
module motor_model
(
	input  wire logic               pclk,      // bench clock
	input  wire logic               presetn,   // async reset, low
	input  wire logic               loop_tick, // update strobe
	input  wire logic               locked,    // lock state flag
	input  wire logic signed [15:0] pos_corr,  // lock position error
	input  wire logic               kick_en,   // apply external push
	input  wire logic signed [31:0] kick,      // push size, counts
	output logic signed [31:0]      enc_pos    // encoder count
);
	timeunit 1ns;
	timeprecision 1ps;
	// shaft steps one count a tick toward the lock point
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enc_pos <= 32'sh0000_0100;
		else if (kick_en)
			enc_pos <= enc_pos + kick;
		else if (loop_tick && locked)
			enc_pos <= enc_pos + {31'h0000_0000, pos_corr > 0}
				- {31'h0000_0000, pos_corr < 0};
	end
endmodule

// File: dv/speed_aux_bench.sv
// self-checking bench for the speed-mode helper
module speed_aux_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                 pclk, presetn, psel, penable, pwrite, er;
	logic                 loop_tick, kick_en, pready, pslverr;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, rd;
	logic signed [15:0]   speed_cmd, speed_fb, eff_cmd, pos_corr;
	logic signed [31:0]   enc_pos, kick, lock_at;
	logic [15:0]          tlb_limit;
	speed_aux_pkg::din_s  din_pins, d;
	speed_aux_pkg::dout_s dout, o;
	int                   errors, checks, i, f, prev, c;
	// design and motor model
	speed_aux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .loop_tick(loop_tick), .speed_cmd(speed_cmd),
		.speed_fb(speed_fb), .enc_pos(enc_pos), .din_pins(din_pins),
		.eff_cmd(eff_cmd), .pos_corr(pos_corr), .tlb_limit(tlb_limit),
		.dout(dout));
	motor_model u_motor (.pclk(pclk), .presetn(presetn),
		.loop_tick(loop_tick), .locked(dout.locked), .pos_corr(pos_corr),
		.kick_en(kick_en), .kick(kick), .enc_pos(enc_pos));
	// 50 mhz clock
	always #10 pclk = ~pclk;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (n == 16)
		begin
			errors++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one control update, outputs settled on return
	task automatic tick(input logic signed [15:0] cm,
		input logic signed [15:0] fb);
		@(posedge pclk);
		speed_cmd <= cm;
		speed_fb <= fb;
		loop_tick <= 1'b1;
		@(posedge pclk);
		loop_tick <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
	endtask
	task automatic set_din(input speed_aux_pkg::din_s v);
		@(posedge pclk);
		din_pins <= v;
		repeat (4) @(posedge pclk);
	endtask
	function automatic int mag(input int v);
		return v < 0 ? -v : v;
	endfunction
	// reference command shaping
	function automatic int shape(input int x, input speed_aux_pkg::din_s p);
		int s;
		s = p.command_reverse_input ? -x : x;
		if (p.forward_jog_input)
			s += speed_aux_pkg::JOG_RST;
		if (p.reverse_jog_input)
			s -= speed_aux_pkg::JOG_RST;
		if (p.speed_pause_input)
			s = 0;
		return s > 32767 ? 32767 : (s < -32767 ? -32767 : s);
	endfunction
	// reference status flags at default thresholds
	function automatic speed_aux_pkg::dout_s status(input int v, input int p,
		input int e);
		speed_aux_pkg::dout_s o;
		int z;
		z = speed_aux_pkg::ZSPD_RST;
		o.speed_consistency_output = mag(v - e) < speed_aux_pkg::CONS_RST;
		o.speed_reached_output = mag(v) > speed_aux_pkg::REACH_RST;
		o.zero_speed_output = mag(v) < z;
		o.accelerating_output = mag(v - p) > speed_aux_pkg::ACC_RST
			&& mag(v) > mag(p);
		o.decelerating_output = mag(v - p) > speed_aux_pkg::ACC_RST
			&& mag(v) < mag(p);
		o.forward_rotation_output = v > z;
		o.reverse_rotation_output = v < -z;
		o.locked = 1'b0;
		return o;
	endfunction
	// main sequence
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, loop_tick, kick_en} = '0;
		{paddr, pwdata, speed_cmd, speed_fb, kick} = '0;
		din_pins = '0;
		errors = 0;
		checks = 0;
		void'($urandom(94236));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		check(tlb_limit, speed_aux_pkg::TLB_VAL_RST);
		apb(1'b0, speed_aux_pkg::ZL_THR_ADDR, 32'h0);
		check(rd, speed_aux_pkg::ZL_THR_RST);
		check(er, 1'b0);
		apb(1'b0, 8'h3c, 32'h0);
		check(er, 1'b1);
		check(rd, speed_aux_pkg::UNMAPPED_RD);
		apb(1'b1, speed_aux_pkg::TLB_VAL_ADDR, 32'h0000_0dac);
		apb(1'b0, speed_aux_pkg::TLB_VAL_ADDR, 32'h0);
		check(rd, speed_aux_pkg::TLB_VAL_MAX);
		check(tlb_limit, speed_aux_pkg::TLB_VAL_MAX);
		apb(1'b1, speed_aux_pkg::TLB_SRC_ADDR, 32'h1);
		repeat (2) @(posedge pclk);
		check(tlb_limit, 32'h0);
		// first-order filters at default shifts
		tick(0, 400);
		apb(1'b0, speed_aux_pkg::FSPD_ADDR, 32'h0);
		check(rd, 32'(400 >>> speed_aux_pkg::FBK_TC_RST));
		apb(1'b0, speed_aux_pkg::DSPD_ADDR, 32'h0);
		check(32'(signed'(rd) < 100), 32'h1);
		apb(1'b1, speed_aux_pkg::FBK_TC_ADDR, 32'h0);
		apb(1'b1, speed_aux_pkg::DSP_TC_ADDR, 32'h0);
		// status flags against random feedback
		tick(300, 100);
		prev = 100;
		for (i = 0; i < 24; i++)
		begin
			f = i % 4 == 0 ? int'($urandom_range(30)) - 15
				: int'($urandom_range(3000)) - 1500;
			tick(300, 16'(f));
			// status reads the filtered speed of the tick before
			tick(300, 16'(f));
			o = status(f, prev, 300);
			check(dout[7:5], o[7:5]);
			check(dout[4:0], o[4:0]);
			prev = f;
		end
		// command shaping with random inputs
		for (i = 0; i < 32; i++)
		begin
			d = speed_aux_pkg::din_s'({1'b0, 4'($urandom)});
			c = int'($urandom_range(65535)) - 32768;
			if (i == 0)
			begin
				d = speed_aux_pkg::din_s'(5'h0c);
				c = -32768;
			end
			set_din(d);
			tick(16'(c), 0);
			check(eff_cmd, 32'(shape(c, d)));
		end
		// zero lock, push and recovery
		set_din(speed_aux_pkg::din_s'(5'h10));
		tick(3, 0);
		lock_at = enc_pos;
		check(dout.locked, 1'b1);
		check(eff_cmd, 32'h0);
		check(pos_corr, 32'h0);
		@(posedge pclk);
		kick <= 5;
		kick_en <= 1'b1;
		@(posedge pclk);
		kick_en <= 1'b0;
		tick(3, 0);
		check(pos_corr, 32'hffff_fffb);
		repeat (8) tick(3, 0);
		check(32'(mag(enc_pos - lock_at) <= 1), 32'h1);
		check(pos_corr, 32'h0);
		tick(8, 0);
		check(dout.locked, 1'b0);
		check(eff_cmd, 32'h8);
		apb(1'b1, speed_aux_pkg::ZL_THR_ADDR, 32'ha);
		tick(8, 0);
		check(dout.locked, 1'b1);
		check(eff_cmd, 32'h0);
		set_din('0);
		tick(0, 0);
		check(dout.locked, 1'b0);
		report_and_stop();
	end
endmodule
